// >>> hw/temp_readout_params.svh
// constants for the temperature result readout block
`ifndef TEMP_READOUT_PARAMS_SVH
`define TEMP_READOUT_PARAMS_SVH

`define TR_SLAVE_ADDR 7'h48
`define TR_PTR_TEMP 8'h00
`define TR_PTR_RESET 8'h00
`define TR_RESULT_RESET 13'h0000
`define TR_WORD_ZERO 16'h0000
`define TR_BYTE_ZERO 8'h00
`define TR_BITS_PER_BYTE 4'h8
`define TR_CNT_ZERO 4'h0
`define TR_CNT_ONE 4'h1
`define TR_TOP_BIT 3'h7

`endif

// >>> hw/temp_readout_pkg.sv
// types for the temperature result readout block
package temp_readout_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK  = 3'h2,
    ST_RXB  = 3'h3,
    ST_TXB  = 3'h4,
    ST_MACK = 3'h5
  } serial_state_t;
endpackage

// >>> hw/temperature_result_readout.sv
// temperature result register behind a two-wire serial slave port
`timescale 1ns/100ps
`include "temp_readout_params.svh"

module temperature_result_readout (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic conv_done_i,
  input wire logic [12:0] conv_temp_i,
  input wire logic extended_range_select_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [12:0] temp_result_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------
  logic [12:0] temp_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      temp_q <= `TR_RESULT_RESET;
    end else if (conv_done_i) begin
      temp_q <= conv_temp_i;
    end
  end

  assign temp_result_o = temp_q;

  // value is left-justified, flag in bit 0, padding zero
  function automatic logic [15:0] fmt_word(input logic [12:0] t,
                                           input logic em);
    if (em) begin
      fmt_word = {t, 2'h0, em};
    end else begin
      fmt_word = {t[11:0], 3'h0, em};
    end
  endfunction

  // ----------------------------------------------------------------
  // serial slave state machine
  // ----------------------------------------------------------------
  temp_readout_pkg::serial_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [15:0] word_q;
  logic rw_q, ptr_next_q, byte_sel_q, mack_q, oe_q, sda_q;
  logic [7:0] cur_byte;
  logic snap;

  assign cur_byte = byte_sel_q ? word_q[7:0] : word_q[15:8];
  assign snap = scl_fall && (state_q == temp_readout_pkg::ST_ADDR) &&
                (cnt_q == `TR_BITS_PER_BYTE) &&
                (shift_q[7:1] == `TR_SLAVE_ADDR) && shift_q[0];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= temp_readout_pkg::ST_IDLE;
      cnt_q <= `TR_CNT_ZERO;
      shift_q <= `TR_BYTE_ZERO;
      ptr_q <= `TR_PTR_RESET;
      word_q <= `TR_WORD_ZERO;
      rw_q <= 1'b0;
      ptr_next_q <= 1'b0;
      byte_sel_q <= 1'b0;
      mack_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= temp_readout_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= temp_readout_pkg::ST_ADDR;
      cnt_q <= `TR_CNT_ZERO;
      oe_q <= 1'b0;
    end else begin
      case (state_q)
        temp_readout_pkg::ST_ADDR,
        temp_readout_pkg::ST_RXB: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s_q};
            cnt_q <= cnt_q + `TR_CNT_ONE;
          end else if (scl_fall && cnt_q == `TR_BITS_PER_BYTE) begin
            if (state_q == temp_readout_pkg::ST_RXB) begin
              if (ptr_next_q) begin
                ptr_q <= shift_q;
              end
              ptr_next_q <= 1'b0;
              state_q <= temp_readout_pkg::ST_ACK;
              oe_q <= 1'b1;
            end else if (shift_q[7:1] == `TR_SLAVE_ADDR) begin
              rw_q <= shift_q[0];
              ptr_next_q <= ~shift_q[0];
              byte_sel_q <= 1'b0;
              if (shift_q[0]) begin
                // frozen here so a conversion mid-read cannot tear the word
                word_q <= (ptr_q == `TR_PTR_TEMP) ?
                  fmt_word(temp_q, extended_range_select_i) :
                  `TR_WORD_ZERO;
              end
              state_q <= temp_readout_pkg::ST_ACK;
              oe_q <= 1'b1;
            end else begin
              state_q <= temp_readout_pkg::ST_IDLE;
            end
          end
        end
        temp_readout_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_q <= `TR_CNT_ZERO;
            if (rw_q) begin
              state_q <= temp_readout_pkg::ST_TXB;
              oe_q <= ~cur_byte[`TR_TOP_BIT];
            end else begin
              state_q <= temp_readout_pkg::ST_RXB;
              oe_q <= 1'b0;
            end
          end
        end
        temp_readout_pkg::ST_TXB: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + `TR_CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_q == `TR_BITS_PER_BYTE) begin
              state_q <= temp_readout_pkg::ST_MACK;
              oe_q <= 1'b0;
            end else begin
              oe_q <= ~cur_byte[`TR_TOP_BIT - cnt_q[2:0]];
            end
          end
        end
        temp_readout_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s_q;
          end else if (scl_fall) begin
            cnt_q <= `TR_CNT_ZERO;
            if (mack_q) begin
              // msb byte then lsb byte, wrapping on longer reads
              byte_sel_q <= ~byte_sel_q;
              oe_q <= byte_sel_q ? ~word_q[15] : ~word_q[7];
              state_q <= temp_readout_pkg::ST_TXB;
            end else begin
              // early not-acknowledge simply ends the read
              state_q <= temp_readout_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sda_q <= 1'b0;
    end else begin
      sda_q <= 1'b0;
    end
  end

  assign sda_o = sda_q;
  assign sda_oe_o = oe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic in_tx, ptr_wr;
  assign in_tx = (state_q == temp_readout_pkg::ST_TXB) ||
                 (state_q == temp_readout_pkg::ST_MACK);
  assign ptr_wr = scl_fall && (state_q == temp_readout_pkg::ST_RXB) &&
                  (cnt_q == `TR_BITS_PER_BYTE) && ptr_next_q &&
                  !bus_stop && !bus_start;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  result_load_a: assert property (conv_done_i |=>
    temp_q == $past(conv_temp_i)) else $error("result not loaded");
  normal_word_a: assert property (
    snap && !extended_range_select_i && ptr_q == `TR_PTR_TEMP |=>
    word_q[15:4] == $past(temp_q[11:0])) else $error("normal word wrong");
  ext_word_a: assert property (
    snap && extended_range_select_i && ptr_q == `TR_PTR_TEMP |=>
    word_q[15:3] == $past(temp_q)) else $error("extended word wrong");
  sign_bit_a: assert property (snap && !extended_range_select_i &&
    ptr_q == `TR_PTR_TEMP |=> word_q[15] == $past(temp_q[11]))
    else $error("sign bit wrong");
  fmt_flag_a: assert property (snap && ptr_q == `TR_PTR_TEMP |=>
    word_q[0] == $past(extended_range_select_i))
    else $error("format flag wrong");
  unused_zero_a: assert property (snap |=>
    word_q[2:1] == 2'h0 &&
    (word_q[3] == 1'b0 || $past(extended_range_select_i)))
    else $error("unused bits not zero");
  // reset must not disable this one, or it could never fire
  reset_zero_a: assert property (disable iff (1'b0)
    rst_i |=> temp_q == `TR_RESULT_RESET) else $error("reset value not zero");
  msb_first_a: assert property (
    state_q == temp_readout_pkg::ST_ACK && rw_q && scl_fall &&
    !bus_stop && !bus_start && !byte_sel_q |=>
    oe_q == ~word_q[15]) else $error("msb not sent first");
  ptr_store_a: assert property (ptr_wr |=>
    ptr_q == $past(shift_q)) else $error("pointer not stored");
  snap_hold_a: assert property (in_tx && $past(in_tx) |->
    $stable(word_q)) else $error("snapshot changed mid read");
  idle_release_a: assert property (
    state_q == temp_readout_pkg::ST_IDLE |-> !oe_q)
    else $error("line held in idle");

  two_byte_read_c: cover property (in_tx && byte_sel_q);
  short_read_c: cover property (state_q == temp_readout_pkg::ST_MACK &&
    !mack_q && scl_fall && !byte_sel_q);
  ptr_write_c: cover property (ptr_wr);
  ext_snap_c: cover property (snap && extended_range_select_i);

endmodule

// >>> tb/serial_master_model.sv
// two-wire bus master model facing the readout block's serial port
`timescale 1ns/100ps

module serial_master_model (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ------------------------------------------------------------
  // bus conditions; 10 clocks a phase clears the slave's 3-stage pin synchroniser
  // ------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick();
    repeat (10) @(negedge sys_clk_i);
  endtask

  task automatic start_cond();
    sda_low_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_low_o = 1'b1;
    tick();
    scl_o = 1'b0;
    tick();
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_low_o = 1'b0;
    tick();
  endtask

  // a one is sent by releasing, so the pull-up sets the level
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    tick();
    scl_o = 1'b1;
    tick();
    r = sda_i;
    scl_o = 1'b0;
    tick();
  endtask

  // mack high acks a read byte so the slave goes on; low ends it
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(~mack, r);
    ack = ~r;
  endtask
endmodule

// >>> tb/temperature_result_readout_bench.sv
// self-checking bench for the temperature result readout block
`timescale 1ns/100ps
`include "temp_readout_params.svh"

module temperature_result_readout_bench;
  logic sys_clk_i, rst_i, conv_done_i, extended_range_select_i;
  logic [12:0] conv_temp_i, temp_result_o;
  logic scl, sda_low, sda_o, sda_oe_o, a;
  logic [15:0] w, e;
  // open-drain wire with pull-up: low if either side pulls
  wire logic sda = ~((sda_oe_o & ~sda_o) | sda_low);
  int err_total = 0;
  int total_checks = 0;
  logic [12:0] vals [4] = '{13'h0190, 13'h1E70, 13'h0960, 13'h1FFC};

  temperature_result_readout temperature_result_readout_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .conv_done_i(conv_done_i),
    .conv_temp_i(conv_temp_i),
    .extended_range_select_i(extended_range_select_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .temp_result_o(temp_result_o));

  serial_master_model serial_master_model_inst (
    .sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] word_of(input logic [12:0] v,
                                          input logic em);
    word_of = em ? {v, 3'h1} : {v[11:0], 4'h0};
  endfunction

  task automatic load(input logic [12:0] v);
    conv_done_i = 1'b1;
    conv_temp_i = v;
    @(negedge sys_clk_i);
    conv_done_i = 1'b0;
  endtask

  task automatic set_ptr(input logic [7:0] adr, input logic [7:0] p,
                         output logic ack);
    logic [7:0] q;
    logic a2;
    serial_master_model_inst.start_cond();
    serial_master_model_inst.xfer(adr, 1'b0, q, ack);
    serial_master_model_inst.xfer(p, 1'b0, q, a2);
    serial_master_model_inst.stop_cond();
  endtask

  // mid loads a new result between the two bytes of the read
  task automatic read_word(input logic full, input logic mid,
                           input logic [12:0] nv, output logic [15:0] r);
    logic a1;
    r = 16'hFFFF;
    serial_master_model_inst.start_cond();
    serial_master_model_inst.xfer({`TR_SLAVE_ADDR, 1'b1}, 1'b0, r[15:8], a1);
    check({15'h0, a1}, 16'h0001);
    serial_master_model_inst.xfer(8'hFF, full, r[15:8], a1);
    if (mid) load(nv);
    if (full) serial_master_model_inst.xfer(8'hFF, 1'b0, r[7:0], a1);
    serial_master_model_inst.stop_cond();
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    conv_done_i = 1'b0;
    conv_temp_i = 13'h0000;
    extended_range_select_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    check({3'h0, temp_result_o}, 16'h0000);
    read_word(1'b1, 1'b0, 13'h0000, w);
    check(w, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      extended_range_select_i = k[0];
      load(vals[k/2]);
      check({3'h0, temp_result_o}, {3'h0, vals[k/2]});
      read_word(1'b1, 1'b0, 13'h0000, w);
      check(w, word_of(vals[k/2], k[0]));
      check(w, word_of(vals[k/2], k[0]));
    end
    conv_done_i = 1'b1;
    conv_temp_i = 13'h0AAA;
    @(negedge sys_clk_i);
    conv_temp_i = 13'h1555;
    @(negedge sys_clk_i);
    conv_done_i = 1'b0;
    check({3'h0, temp_result_o}, 16'h1555);
    e = word_of(13'h1555, 1'b1);
    read_word(1'b0, 1'b0, 13'h0000, w);
    check({8'h00, w[15:8]}, {8'h00, e[15:8]});
    read_word(1'b1, 1'b1, 13'h0123, w);
    check(w, e);
    check({3'h0, temp_result_o}, 16'h0123);
    set_ptr({`TR_SLAVE_ADDR, 1'b0}, 8'h01, a);
    check({15'h0, a}, 16'h0001);
    read_word(1'b1, 1'b0, 13'h0000, w);
    check(w, 16'h0000);
    set_ptr({`TR_SLAVE_ADDR, 1'b0}, 8'h00, a);
    set_ptr({7'h49, 1'b0}, 8'h01, a);
    check({15'h0, a}, 16'h0000);
    repeat (2) begin
      read_word(1'b1, 1'b0, 13'h0000, w);
      check(w, word_of(13'h0123, 1'b1));
    end
    // mid-run reset must clear both the result and the pointer
    set_ptr({`TR_SLAVE_ADDR, 1'b0}, 8'h01, a);
    check({15'h0, a}, 16'h0001);
    rst_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    check({3'h0, temp_result_o}, 16'h0000);
    read_word(1'b1, 1'b0, 13'h0000, w);
    check(w, word_of(13'h0000, 1'b1));
    test_done();
  end

  // a full run needs about 15400 clocks
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    err_total++;
    test_done();
  end
endmodule
